/* File: slsc_checker.sv */
// Port checker for slsc_top: APB answer, header enables, SYNC~ watch.
// Assumes it is bound to slsc_top and sees only that module's ports.
`timescale 1ns/10ps
module slsc_checker (
  input wire CLK, RST, PSEL, PENABLE, PREADY, PSLVERR, SYNC_N,
  input wire SYNC_WORD_VALID, HDR_CRC_EN, HDR_FEC_EN, SYNC_REQ,
  input wire [7:0] HDR_CMD_BITS,
  input wire [31:0] SYNC_WORD_IN, SYNC_WORD_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  AST_CMD_ZERO:
    assert property (HDR_CMD_BITS == 8'h00) else $error("cmd bits set");
  AST_HDR_EXCL:
    assert property (!(HDR_CRC_EN && HDR_FEC_EN)) else $error("crc and fec");
  AST_WORD_CAP:
    assert property (SYNC_WORD_VALID |=> SYNC_WORD_OUT == $past(SYNC_WORD_IN))
      else $error("word lost");
  AST_REQ_LOW:
    assert property ($rose(SYNC_REQ) |-> !$past(SYNC_N)) else $error("req no low");
  // Two high samples, so either reading of the fall edge passes
  AST_HIGH_CLR:
    assert property (SYNC_N [*2] |=> !SYNC_REQ) else $error("req after high");
  AST_RDY_ANS:
    assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("no ready");
  AST_RDY_PULSE:
    assert property (PREADY |=> !PREADY) else $error("ready long");
  AST_ERR_RDY:
    assert property (PSLVERR |-> PREADY) else $error("err alone");
endmodule // slsc_checker
bind slsc_top slsc_checker chk (.*);

/* File: slsc_consts.vh */
// Constants for the serial link sync control block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
`ifndef SLSC_CONSTS_VH
`define SLSC_CONSTS_VH

// Printed offsets are not all multiples of four: they are word indices
`define SLSC_IDX_SH_SELECT 12'h20F
`define SLSC_IDX_SYNC_REQUEST_THRESHOLD 12'h210
`define SLSC_IDX_CONTROL 12'h220
`define SLSC_IDX_STATUS 12'h221

`define SLSC_RST_SH_SELECT 8'h00
`define SLSC_RST_SYNC_REQUEST_THRESHOLD 8'h03
`define SLSC_RST_CONTROL 8'h00

`define SLSC_SH_CRC12 2'h0
`define SLSC_SH_FEC 2'h2

// Control register fields
`define SLSC_CTL_TX_EN 0
`define SLSC_CTL_MODE_64B66B 1

// Status register fields
`define SLSC_ST_SYNC_LEVEL 5
`define SLSC_ST_REQ_SEEN 0
`define SLSC_ST_ERR_SEEN 1

`define SLSC_SYNC_WORD_BITS 32
`endif

/* File: slsc_rx_model.sv */
// Receiver model: holds SYNC~ low for a requested number of link clocks.
// Assumes go is a one-cycle strobe from the bench.
`timescale 1ns/10ps
module slsc_rx_model (
  input wire clk,
  input wire go,
  input wire [5:0] n,
  output wire sync_n
);
  reg [5:0] left_q = 6'h00;
  always @(posedge clk)
  begin
    if (go)
      left_q <= n;
    else if (left_q != 6'h00)
      left_q <= left_q - 6'h01;
  end
  // Error reporting off: only lows of the asked length
  assign sync_n = (left_q == 6'h00);
endmodule // slsc_rx_model

/* File: slsc_top.v */
// Sync control for a 64B/66B multi-lane transmitter: header selection and SYNC~ watch.
// Assumes CLK is the link clock (fS/2) and SYNC_N is already synchronous to it.
//
// What this block does
// - A two-bit header select picks CRC-12 at 0 (default) or FEC at 2; 1 and 3 are reserved.
// - The header select only acts while the link mode is a 64B/66B mode.
// - The sync word is built from 32 bits of data per multi-block.
// - No command channel: every command field is driven as zero, giving idle headers.
// - SYNC~ is sampled on every link clock cycle.
// - A shorter low run is an error report and causes no action.
// - Status bit 5 shows the present SYNC~ level, 0 asserted and 1 deasserted.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`include "slsc_consts.vh"

module slsc_top #(
  parameter THRESH_W = 5
)
(
  CLK,
  RST,
  PSEL,
  PENABLE,
  PWRITE,
  PADDR,
  PWDATA,
  PRDATA,
  PREADY,
  PSLVERR,
  SYNC_N,
  SYNC_WORD_IN,
  SYNC_WORD_VALID,
  HDR_CRC_EN,
  HDR_FEC_EN,
  HDR_CMD_BITS,
  SYNC_WORD_OUT,
  SYNC_REQ,
  LINK_TX_EN
);
  input wire CLK;
  input wire RST;
  input wire PSEL;
  input wire PENABLE;
  input wire PWRITE;
  input wire [13:0] PADDR;
  input wire [31:0] PWDATA;
  output reg [31:0] PRDATA;
  output reg PREADY;
  output reg PSLVERR;
  input wire SYNC_N;
  input wire [`SLSC_SYNC_WORD_BITS-1:0] SYNC_WORD_IN;
  input wire SYNC_WORD_VALID;
  output reg HDR_CRC_EN;
  output reg HDR_FEC_EN;
  output reg [7:0] HDR_CMD_BITS;
  output reg [`SLSC_SYNC_WORD_BITS-1:0] SYNC_WORD_OUT;
  output reg SYNC_REQ;
  output reg LINK_TX_EN;

  // ****************************************
  // Register file
  // ****************************************
  reg [7:0] sh_select_q;
  reg [7:0] sh_select_d;
  reg [7:0] sync_request_threshold_q;
  reg [7:0] sync_request_threshold_d;
  reg [7:0] control_q;
  reg [7:0] control_d;
  reg [31:0] rdata_d;
  reg req_seen_q;
  reg req_seen_d;
  reg err_seen_q;
  reg err_seen_d;
  reg [THRESH_W:0] low_cnt_q;
  reg [THRESH_W:0] low_cnt_d;
  reg sync_level_q;

  wire [11:0] word_idx;
  wire aligned;
  wire known;
  wire access;
  wire done;
  wire wr;
  wire rd;
  wire st_wr;
  wire [7:0] status;
  wire mode_66;
  wire [THRESH_W-1:0] thresh;
  wire run_done;
  wire run_short;

  // ****************************************
  // Shared decode and arithmetic
  // ****************************************
  // Only the four mapped words answer without an error
  function is_known;
    input [11:0] idx;
    begin
      is_known = (idx == `SLSC_IDX_SH_SELECT) || (idx == `SLSC_IDX_SYNC_REQUEST_THRESHOLD) ||
                 (idx == `SLSC_IDX_CONTROL) || (idx == `SLSC_IDX_STATUS);
    end
  endfunction

  // Registers are 8 bits wide; the rest of the bus word reads as zero
  function [31:0] bus_word;
    input [7:0] value;
    begin
      bus_word = {24'h000000, value};
    end
  endfunction

  // A run counts as a request once it is longer than the threshold
  function past_thresh;
    input [THRESH_W:0] count;
    input [THRESH_W-1:0] limit;
    begin
      past_thresh = (count > {1'b0, limit});
    end
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  // Word index is the byte address over four
  assign word_idx = PADDR[13:2];
  assign aligned = (PADDR[1:0] == 2'h0);
  // Unaligned or unmapped addresses are refused with PSLVERR and change nothing
  assign known = aligned && is_known(word_idx);
  // First access cycle; the answer is registered, so one wait state follows
  assign access = PSEL && PENABLE && !PREADY;
  // Completing edge: writes land exactly where the master samples PREADY
  assign done = PSEL && PENABLE && PREADY;
  assign wr = done && PWRITE && known;
  assign rd = access && !PWRITE && known;
  assign st_wr = wr && (word_idx == `SLSC_IDX_STATUS);

  // ****************************************
  // Register writes
  // ****************************************
  // Reserved bits are stored as written so reads return them; software keeps them 0
  always @*
  begin
    sh_select_d = sh_select_q;
    sync_request_threshold_d = sync_request_threshold_q;
    control_d = control_q;
    if (wr)
    begin
      case (word_idx)
        `SLSC_IDX_SH_SELECT: sh_select_d = PWDATA[7:0];
        `SLSC_IDX_SYNC_REQUEST_THRESHOLD: sync_request_threshold_d = PWDATA[7:0];
        `SLSC_IDX_CONTROL: control_d = PWDATA[7:0];
        default: control_d = control_q;
      endcase
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Writes and refused reads return zero
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (rd)
    begin
      case (word_idx)
        `SLSC_IDX_SH_SELECT: rdata_d = bus_word(sh_select_q);
        `SLSC_IDX_SYNC_REQUEST_THRESHOLD: rdata_d = bus_word(sync_request_threshold_q);
        `SLSC_IDX_CONTROL: rdata_d = bus_word(control_q);
        `SLSC_IDX_STATUS: rdata_d = bus_word(status);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  assign status = {2'h0, sync_level_q, 3'h0, err_seen_q, req_seen_q};

  // ****************************************
  // Bus answer and register storage
  // ****************************************
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sh_select_q <= `SLSC_RST_SH_SELECT;
      sync_request_threshold_q <= `SLSC_RST_SYNC_REQUEST_THRESHOLD;
      control_q <= `SLSC_RST_CONTROL;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      sh_select_q <= sh_select_d;
      sync_request_threshold_q <= sync_request_threshold_d;
      control_q <= control_d;
      // PREADY, PSLVERR and PRDATA stand together for the completing cycle
      PREADY <= access;
      PSLVERR <= access && !known;
      // Read data holds between accesses
      if (access)
        PRDATA <= rdata_d;
    end
  end

  // ****************************************
  // Sync header selection
  // ****************************************
  assign mode_66 = control_q[`SLSC_CTL_MODE_64B66B];

  // Reserved select codes send neither CRC nor FEC rather than guessing
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      HDR_CRC_EN <= 1'b0;
      HDR_FEC_EN <= 1'b0;
      HDR_CMD_BITS <= 8'h00;
      SYNC_WORD_OUT <= 32'h0000_0000;
      LINK_TX_EN <= 1'b0;
    end
    else
    begin
      // Transmit enable only gates the link; it does not lock the registers
      LINK_TX_EN <= control_q[`SLSC_CTL_TX_EN];
      // Outside 64B/66B modes the select is held but has no effect
      HDR_CRC_EN <= mode_66 && (sh_select_q[1:0] == `SLSC_SH_CRC12);
      HDR_FEC_EN <= mode_66 && (sh_select_q[1:0] == `SLSC_SH_FEC);
      // Command channel is not supported: idle headers only
      HDR_CMD_BITS <= 8'h00;
      // The word is taken whole, once per multi-block, when the source marks it valid
      if (SYNC_WORD_VALID)
        SYNC_WORD_OUT <= SYNC_WORD_IN;
    end
  end

  // ****************************************
  // SYNC~ watch: low-run counter
  // ****************************************
  // The threshold is read live; software keeps it steady while the link is enabled
  assign thresh = sync_request_threshold_q[THRESH_W-1:0];

  // Counter saturates one past the threshold, so a long low gives one rising request
  always @*
  begin
    low_cnt_d = low_cnt_q;
    // A high sample always restarts the run
    if (SYNC_N)
      low_cnt_d = {(THRESH_W+1){1'b0}};
    else if (!past_thresh(low_cnt_q, thresh))
      low_cnt_d = low_cnt_q + {{THRESH_W{1'b0}}, 1'b1};
  end

  // ****************************************
  // SYNC~ watch: request and status flags
  // ****************************************
  // Request on the sample that completes threshold plus one lows
  assign run_done = !SYNC_N && past_thresh(low_cnt_d, thresh);
  // A run that ends at or below the threshold is only an error report
  assign run_short = SYNC_N && (low_cnt_q != {(THRESH_W+1){1'b0}}) &&
                     !past_thresh(low_cnt_q, thresh);

  // Write-one-to-clear flags; an event in the clearing cycle wins so none is lost
  always @*
  begin
    req_seen_d = req_seen_q;
    err_seen_d = err_seen_q;
    if (run_done)
      req_seen_d = 1'b1;
    else if (st_wr && PWDATA[`SLSC_ST_REQ_SEEN])
      req_seen_d = 1'b0;
    if (run_short)
      err_seen_d = 1'b1;
    else if (st_wr && PWDATA[`SLSC_ST_ERR_SEEN])
      err_seen_d = 1'b0;
  end

  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      low_cnt_q <= {(THRESH_W+1){1'b0}};
      // Idle level of SYNC~ is high, so status starts as deasserted
      sync_level_q <= 1'b1;
      SYNC_REQ <= 1'b0;
      req_seen_q <= 1'b0;
      err_seen_q <= 1'b0;
    end
    else
    begin
      low_cnt_q <= low_cnt_d;
      // One cycle behind the pin, as every status bit is registered
      sync_level_q <= SYNC_N;
      // Request level stays up while the low run lasts
      SYNC_REQ <= run_done;
      // A short run is only noted; nothing else reacts to it
      req_seen_q <= req_seen_d;
      err_seen_q <= err_seen_d;
    end
  end

endmodule // slsc_top

/* File: tb_top.sv */
// Bench for slsc_top: registers over APB, header select, SYNC~ requests.
// Assumes the checker is bound and the receiver model drives SYNC~.
`timescale 1ns/10ps
`include "slsc_consts.vh"
module tb_top;
  localparam [13:0] A_SEL = {`SLSC_IDX_SH_SELECT, 2'h0};
  localparam [13:0] A_THR = {`SLSC_IDX_SYNC_REQUEST_THRESHOLD, 2'h0};
  localparam [13:0] A_CTL = {`SLSC_IDX_CONTROL, 2'h0};
  localparam [13:0] A_ST = {`SLSC_IDX_STATUS, 2'h0};
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, go = 0, er;
  logic SYNC_WORD_VALID = 0;
  logic [13:0] PADDR = 0;
  logic [31:0] PWDATA = 0, SYNC_WORD_IN = 0, rd;
  logic [5:0] n = 0;
  wire [31:0] PRDATA, SYNC_WORD_OUT;
  wire [7:0] HDR_CMD_BITS;
  wire PREADY, PSLVERR, HDR_CRC_EN, HDR_FEC_EN, SYNC_REQ, LINK_TX_EN, SYNC_N;
  int failures = 0, cmp_count = 0, cyc = 0, i;
  always #4 CLK = ~CLK;
  slsc_rx_model rx (.clk(CLK), .go(go), .n(n), .sync_n(SYNC_N));
  slsc_top dut (.*);
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Writes land on the completing edge; outputs follow one edge later
    repeat (2) @(posedge CLK);
  endtask
  task pulse(input logic [5:0] k, input int w);
    go <= 1'b1;
    n <= k;
    @(posedge CLK);
    go <= 1'b0;
    repeat (w) @(posedge CLK);
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Generous ceiling: the sequence needs under two hundred cycles
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      complete_run;
    end
  end
  initial
  begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, A_THR, '0);
    chk(rd, 32'h3);
    apb(1'b0, A_SEL, '0);
    chk(rd, 32'h0);
    chk(HDR_CMD_BITS, 8'h00);
    apb(1'b1, A_CTL, 32'h2);
    chk(LINK_TX_EN, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, A_SEL, i);
      chk({HDR_FEC_EN, HDR_CRC_EN}, {i == 2, i == 0});
    end
    apb(1'b1, A_SEL, '0);
    apb(1'b1, A_CTL, '0);
    chk({HDR_FEC_EN, HDR_CRC_EN}, 2'h0);
    apb(1'b1, 14'h0004, 32'hFF);
    chk(er, 1'b1);
    apb(1'b1, A_SEL + 14'h1, 32'h2);
    chk(er, 1'b1);
    apb(1'b0, A_SEL, '0);
    chk(rd, 32'h0);
    pulse(6'h03, 6);
    apb(1'b0, A_ST, '0);
    chk(rd[1:0], 2'h2);
    apb(1'b1, A_ST, 32'h3);
    pulse(6'h14, 6);
    chk(SYNC_REQ, 1'b1);
    apb(1'b0, A_ST, '0);
    chk({rd[5], rd[0]}, 2'h1);
    repeat (20) @(posedge CLK);
    chk(SYNC_REQ, 1'b0);
    apb(1'b0, A_ST, '0);
    chk({rd[5], rd[1]}, 2'h2);
    apb(1'b1, A_ST, 32'h3);
    apb(1'b1, A_THR, '0);
    pulse(6'h01, 4);
    apb(1'b0, A_ST, '0);
    chk(rd[1:0], 2'h1);
    SYNC_WORD_IN <= 32'hA5C31E0F;
    SYNC_WORD_VALID <= 1'b1;
    @(posedge CLK);
    SYNC_WORD_VALID <= 1'b0;
    @(posedge CLK);
    chk(SYNC_WORD_OUT, 32'hA5C31E0F);
    apb(1'b1, A_CTL, 32'h1);
    chk(LINK_TX_EN, 1'b1);
    apb(1'b0, A_CTL, '0);
    chk(rd, 32'h1);
    complete_run;
  end
endmodule // tb_top
